// ===== dss_pkg.sv
`default_nettype none
package dss_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int REG_AW = 8;

  // ==========================================================================
  // Register map
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_STATE_ONE = 8'h04;
  localparam logic [7:0] OFS_STATE_TWO = 8'h08;
  localparam logic [7:0] OFS_STATE_THREE = 8'h0c;
  localparam logic [7:0] OFS_COMP_A = 8'h10;
  localparam logic [7:0] OFS_COMP_B = 8'h14;
  localparam logic [7:0] OFS_COMP_C = 8'h18;
  localparam logic [7:0] OFS_COMP_CTRL = 8'h1c;
  localparam logic [7:0] OFS_COMP_DATA = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h28;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h2c;

  // Control register bits.
  localparam int CTL_ARM = 0;
  localparam int CTL_TRIG = 1;
  localparam int CTL_RANGE = 2;
  localparam int CTL_BRK = 3;
  localparam int CTL_TSOURCE = 4;
  localparam int CTL_TALIGN = 5;
  localparam int CTL_DBGBRK = 6;
  localparam int CTL_W = 7;

  // Comparator control: enables [2:0], tag select [5:3], data compare on channel zero [6].
  localparam int CC_EN_LSB = 0;
  localparam int CC_TAG_LSB = 3;
  localparam int CC_DATA = 6;
  localparam int CC_W = 7;

  localparam int IRQ_FINAL = 0;
  localparam int IRQ_BKPT = 1;
  localparam int IRQ_TAGHIT = 2;
  localparam int IRQ_W = 3;

  localparam logic [3:0] SCR_RESET = 4'hf;

  // Per-channel transition targets.
  localparam logic [2:0] TGT_NONE = 3'h0;
  localparam logic [2:0] TGT_S1 = 3'h1;
  localparam logic [2:0] TGT_S2 = 3'h2;
  localparam logic [2:0] TGT_S3 = 3'h3;
  localparam logic [2:0] TGT_FINAL = 3'h4;
  localparam logic [2:0] TGT_NEXT = 3'h5;

  typedef enum logic [1:0] {
    DSS_STATE_ONE,
    DSS_STATE_TWO,
    DSS_STATE_THREE,
    DSS_STATE_FINAL
  } dss_state_type;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
    logic data_valid;
    logic [DATA_W-1:0] data;
  } dss_bus_type;

endpackage

`default_nettype wire

// ===== dss_sequencer.sv
`timescale 1ns/1ps
`default_nettype none

module dss_sequencer (
  input wire logic clock,
  input wire logic reset,
  input wire logic [dss_pkg::REG_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire dss_pkg::dss_bus_type cpu_bus,
  input wire logic [2:0] tag_hit,
  input wire logic bdm_active,
  input wire logic trace_full,
  input wire logic bkpt_ack,
  output logic [2:0] tag_request,
  output logic trigger,
  output logic bkpt_request,
  output logic irq
);

  // ==========================================================================
  // Registers
  logic [dss_pkg::CTL_W-1:0] control;
  logic [3:0] state_one_control;
  logic [3:0] state_two_control;
  logic [3:0] state_three_control;
  logic [dss_pkg::ADDR_W-1:0] comparator_a;
  logic [dss_pkg::ADDR_W-1:0] comparator_b;
  logic [dss_pkg::ADDR_W-1:0] comparator_c;
  logic [dss_pkg::CC_W-1:0] comp_ctrl;
  logic [dss_pkg::DATA_W-1:0] comp_data;
  logic [dss_pkg::IRQ_W-1:0] irq_status;
  logic [dss_pkg::IRQ_W-1:0] irq_mask;
  logic trig_pulse;
  logic disarm;
  logic wait_trace;
  dss_pkg::dss_state_type state;
  dss_pkg::dss_state_type next_state;
  logic final_enter;
  logic [2:0] tag_pending;
  logic [2:0] raw_match;
  logic [2:0] match;
  logic [2:0] tag_valid;
  logic [2:0] event_vec;
  logic [3:0] cur_code;
  logic [8:0] targets;
  logic [2:0] tgt [3];

  wire logic armed = control[dss_pkg::CTL_ARM];
  wire logic range_mode = control[dss_pkg::CTL_RANGE];

  // ==========================================================================
  // Register writes
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_one_control <= dss_pkg::SCR_RESET;
      state_two_control <= dss_pkg::SCR_RESET;
      state_three_control <= dss_pkg::SCR_RESET;
      comparator_a <= '0;
      comparator_b <= '0;
      comparator_c <= '0;
      comp_ctrl <= '0;
      comp_data <= '0;
      irq_mask <= '0;
    end else if (reg_write) begin
      case (reg_addr)
        dss_pkg::OFS_STATE_ONE: state_one_control <= reg_wdata[3:0];
        dss_pkg::OFS_STATE_TWO: state_two_control <= reg_wdata[3:0];
        dss_pkg::OFS_STATE_THREE: state_three_control <= reg_wdata[3:0];
        dss_pkg::OFS_COMP_A: comparator_a <= reg_wdata[dss_pkg::ADDR_W-1:0];
        dss_pkg::OFS_COMP_B: comparator_b <= reg_wdata[dss_pkg::ADDR_W-1:0];
        dss_pkg::OFS_COMP_C: comparator_c <= reg_wdata[dss_pkg::ADDR_W-1:0];
        dss_pkg::OFS_COMP_CTRL: comp_ctrl <= reg_wdata[dss_pkg::CC_W-1:0];
        dss_pkg::OFS_COMP_DATA: comp_data <= reg_wdata[dss_pkg::DATA_W-1:0];
        dss_pkg::OFS_IRQ_MASK: irq_mask <= reg_wdata[dss_pkg::IRQ_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // The trigger bit never stores; it acts once in the cycle after the write, and only if the same write sets the arm bit.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      control <= '0;
      trig_pulse <= 1'b0;
    end else begin
      trig_pulse <= 1'b0;
      if (reg_write && reg_addr == dss_pkg::OFS_CONTROL) begin
        control <= reg_wdata[dss_pkg::CTL_W-1:0];
        control[dss_pkg::CTL_TRIG] <= 1'b0;
        trig_pulse <= reg_wdata[dss_pkg::CTL_TRIG] & reg_wdata[dss_pkg::CTL_ARM];
      end else if (disarm) begin
        control[dss_pkg::CTL_ARM] <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Comparators
  // Channel zero alone carries the range and data checks; in range mode
  // comparator_b supplies the upper bound and so cannot match on its own.
  always_comb begin
    raw_match = 3'b000;
    if (cpu_bus.valid) begin
      if (range_mode) begin
        raw_match[0] = (cpu_bus.addr >= comparator_a) && (cpu_bus.addr <= comparator_b);
      end else begin
        raw_match[0] = (cpu_bus.addr == comparator_a);
      end
      raw_match[1] = (cpu_bus.addr == comparator_b);
      raw_match[2] = (cpu_bus.addr == comparator_c);
      if (comp_ctrl[dss_pkg::CC_DATA] && !comp_ctrl[dss_pkg::CC_TAG_LSB]) begin
        raw_match[0] = raw_match[0] && cpu_bus.data_valid && (cpu_bus.data == comp_data);
      end
    end
    match = raw_match & comp_ctrl[dss_pkg::CC_EN_LSB +: 3];
    match[1] = match[1] & ~range_mode;
    if (!armed || bdm_active || state == dss_pkg::DSS_STATE_FINAL) begin
      match = 3'b000;
    end
  end

  // ==========================================================================
  // Tagging
  // A match on a tagged channel only marks the opcode; the transition waits
  // until the queue reports that the opcode reached its head.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      tag_request <= 3'b000;
    end else begin
      tag_request <= match & comp_ctrl[dss_pkg::CC_TAG_LSB +: 3];
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      tag_pending <= 3'b000;
    end else if (disarm || !armed) begin
      tag_pending <= 3'b000;
    end else begin
      tag_pending <= (tag_pending & ~tag_hit) | tag_request;
    end
  end

  assign tag_valid = (armed && !bdm_active && state != dss_pkg::DSS_STATE_FINAL)
                     ? (tag_hit & tag_pending) : 3'b000;
  assign event_vec = (match & ~comp_ctrl[dss_pkg::CC_TAG_LSB +: 3]) | tag_valid;

  // ==========================================================================
  // Transition decode
  // Returns {channel two, channel one, channel zero} targets. Codes below 8
  // keep their original meaning; the fourth bit opens the forking codes.
  function automatic logic [8:0] decode(input logic [3:0] code);
    logic [8:0] t;
    t = {dss_pkg::TGT_NONE, dss_pkg::TGT_NONE, dss_pkg::TGT_NONE};
    case (code)
      4'h0: t = {dss_pkg::TGT_NONE, dss_pkg::TGT_NONE, dss_pkg::TGT_NEXT};
      4'h1: t = {dss_pkg::TGT_NONE, dss_pkg::TGT_NEXT, dss_pkg::TGT_NONE};
      4'h2: t = {dss_pkg::TGT_NEXT, dss_pkg::TGT_NONE, dss_pkg::TGT_NONE};
      4'h3: t = {dss_pkg::TGT_NONE, dss_pkg::TGT_NONE, dss_pkg::TGT_FINAL};
      4'h4: t = {dss_pkg::TGT_NONE, dss_pkg::TGT_FINAL, dss_pkg::TGT_NONE};
      4'h5: t = {dss_pkg::TGT_FINAL, dss_pkg::TGT_NONE, dss_pkg::TGT_NONE};
      4'h6: t = {dss_pkg::TGT_NONE, dss_pkg::TGT_FINAL, dss_pkg::TGT_NEXT};
      4'h7: t = {dss_pkg::TGT_FINAL, dss_pkg::TGT_FINAL, dss_pkg::TGT_FINAL};
      4'h8: t = {dss_pkg::TGT_FINAL, dss_pkg::TGT_NEXT, dss_pkg::TGT_S3};
      4'h9: t = {dss_pkg::TGT_FINAL, dss_pkg::TGT_NONE, dss_pkg::TGT_S2};
      4'ha: t = {dss_pkg::TGT_S2, dss_pkg::TGT_NONE, dss_pkg::TGT_FINAL};
      4'hb: t = {dss_pkg::TGT_NEXT, dss_pkg::TGT_S1, dss_pkg::TGT_FINAL};
      4'hc: t = {dss_pkg::TGT_FINAL, dss_pkg::TGT_S3, dss_pkg::TGT_S1};
      4'hd: t = {dss_pkg::TGT_S3, dss_pkg::TGT_S2, dss_pkg::TGT_S1};
      4'he: t = {dss_pkg::TGT_FINAL, dss_pkg::TGT_NEXT, dss_pkg::TGT_FINAL};
      default: t = {dss_pkg::TGT_NONE, dss_pkg::TGT_NONE, dss_pkg::TGT_NONE};
    endcase
    return t;
  endfunction

  always_comb begin
    case (state)
      dss_pkg::DSS_STATE_ONE: cur_code = state_one_control;
      dss_pkg::DSS_STATE_TWO: cur_code = state_two_control;
      dss_pkg::DSS_STATE_THREE: cur_code = state_three_control;
      default: cur_code = dss_pkg::SCR_RESET;
    endcase
    targets = decode(cur_code);
  end

  // Resolve the relative target into an absolute one for each channel.
  always_comb begin
    for (int ch = 0; ch < 3; ch++) begin
      tgt[ch] = targets[3*ch +: 3];
      if (tgt[ch] == dss_pkg::TGT_NEXT) begin
        case (state)
          dss_pkg::DSS_STATE_ONE: tgt[ch] = dss_pkg::TGT_S2;
          dss_pkg::DSS_STATE_TWO: tgt[ch] = dss_pkg::TGT_S3;
          default: tgt[ch] = dss_pkg::TGT_FINAL;
        endcase
      end
      if (!event_vec[ch]) begin
        tgt[ch] = dss_pkg::TGT_NONE;
      end
    end
  end

  // Final-state targets win outright; otherwise the lowest channel decides.
  always_comb begin
    next_state = state;
    if (tgt[0] == dss_pkg::TGT_FINAL || tgt[1] == dss_pkg::TGT_FINAL
        || tgt[2] == dss_pkg::TGT_FINAL) begin
      next_state = dss_pkg::DSS_STATE_FINAL;
    end else begin
      for (int ch = 2; ch >= 0; ch--) begin
        case (tgt[ch])
          dss_pkg::TGT_S1: next_state = dss_pkg::DSS_STATE_ONE;
          dss_pkg::TGT_S2: next_state = dss_pkg::DSS_STATE_TWO;
          dss_pkg::TGT_S3: next_state = dss_pkg::DSS_STATE_THREE;
          default: begin
          end
        endcase
      end
    end
    if (trig_pulse && state != dss_pkg::DSS_STATE_FINAL) begin
      next_state = dss_pkg::DSS_STATE_FINAL;
    end
    if (!armed || disarm) begin
      next_state = dss_pkg::DSS_STATE_ONE;
    end
  end

  assign final_enter = (next_state == dss_pkg::DSS_STATE_FINAL)
                       && (state != dss_pkg::DSS_STATE_FINAL);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state <= dss_pkg::DSS_STATE_ONE;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // Trigger and breakpoint
  // With begin alignment and tracing selected the request waits for a full
  // trace buffer; the immediate bit or end alignment requests at once.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      trigger <= 1'b0;
      bkpt_request <= 1'b0;
      wait_trace <= 1'b0;
    end else begin
      trigger <= final_enter;
      // Software disarm must also drop a request, or it would stay up forever.
      if (disarm || !armed) begin
        bkpt_request <= 1'b0;
        wait_trace <= 1'b0;
      end else if (final_enter && control[dss_pkg::CTL_DBGBRK]) begin
        if (control[dss_pkg::CTL_BRK] || !control[dss_pkg::CTL_TSOURCE]
            || !control[dss_pkg::CTL_TALIGN]) begin
          bkpt_request <= 1'b1;
        end else begin
          wait_trace <= 1'b1;
        end
      end else if (wait_trace && trace_full) begin
        bkpt_request <= 1'b1;
        wait_trace <= 1'b0;
      end
    end
  end

  // Without a breakpoint the session ends when tracing no longer needs the
  // final state; with one, the acknowledge ends it.
  always_comb begin
    disarm = 1'b0;
    if (state == dss_pkg::DSS_STATE_FINAL && armed) begin
      if (control[dss_pkg::CTL_DBGBRK]) begin
        disarm = bkpt_request && bkpt_ack;
      end else begin
        disarm = !control[dss_pkg::CTL_TSOURCE] || control[dss_pkg::CTL_BRK] || trace_full;
      end
    end
  end

  // ==========================================================================
  // Interrupts
  logic [dss_pkg::IRQ_W-1:0] irq_set;
  logic [dss_pkg::IRQ_W-1:0] irq_clr;

  always_comb begin
    irq_set = '0;
    irq_set[dss_pkg::IRQ_FINAL] = final_enter;
    irq_set[dss_pkg::IRQ_BKPT] = wait_trace & trace_full & ~disarm & armed;
    if (final_enter && control[dss_pkg::CTL_DBGBRK] && !disarm) begin
      irq_set[dss_pkg::IRQ_BKPT] = control[dss_pkg::CTL_BRK] | ~control[dss_pkg::CTL_TSOURCE]
                                   | ~control[dss_pkg::CTL_TALIGN];
    end
    irq_set[dss_pkg::IRQ_TAGHIT] = |tag_valid;
    irq_clr = '0;
    if (reg_write && reg_addr == dss_pkg::OFS_IRQ_STATUS) begin
      irq_clr = reg_wdata[dss_pkg::IRQ_W-1:0];
    end
  end

  // Setting wins over a clear in the same cycle so no event is lost.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((irq_status & ~irq_clr) | irq_set) & irq_mask);
    end
  end

  // ==========================================================================
  // Register reads
  // Unmapped addresses read as zero; data appears only in the cycle after
  // the read strobe.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= '0;
      if (reg_read) begin
        case (reg_addr)
          dss_pkg::OFS_CONTROL: reg_rdata <= 32'(control);
          dss_pkg::OFS_STATE_ONE: reg_rdata <= 32'(state_one_control);
          dss_pkg::OFS_STATE_TWO: reg_rdata <= 32'(state_two_control);
          dss_pkg::OFS_STATE_THREE: reg_rdata <= 32'(state_three_control);
          dss_pkg::OFS_COMP_A: reg_rdata <= 32'(comparator_a);
          dss_pkg::OFS_COMP_B: reg_rdata <= 32'(comparator_b);
          dss_pkg::OFS_COMP_C: reg_rdata <= 32'(comparator_c);
          dss_pkg::OFS_COMP_CTRL: reg_rdata <= 32'(comp_ctrl);
          dss_pkg::OFS_COMP_DATA: reg_rdata <= 32'(comp_data);
          dss_pkg::OFS_STATUS: reg_rdata <= 32'({tag_pending, wait_trace, bkpt_request, state});
          dss_pkg::OFS_IRQ_STATUS: reg_rdata <= 32'(irq_status);
          dss_pkg::OFS_IRQ_MASK: reg_rdata <= 32'(irq_mask);
          default: reg_rdata <= '0;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ===== dss_seq_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Port checks. Register contents are not visible here, so each check other than a_trig_pulse ties an output
// to a cause that must show at the ports.
module dss_seq_asserts (
  input wire logic clock,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire dss_pkg::dss_bus_type cpu_bus,
  input wire logic [2:0] tag_hit,
  input wire logic bdm_active,
  input wire logic trace_full,
  input wire logic bkpt_ack,
  input wire logic [2:0] tag_request,
  input wire logic trigger,
  input wire logic bkpt_request,
  input wire logic irq
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  property p_trig_pulse;
    trigger |=> !trigger;
  endproperty
  a_trig_pulse: assert property (p_trig_pulse)
    else $error("trigger longer than one cycle");
  property p_trig_cause;
    trigger |-> $past(cpu_bus.valid || tag_hit != 3'h0) || $past(reg_write, 2);
  endproperty
  a_trig_cause: assert property (p_trig_cause)
    else $error("trigger without a match, tag hit or write");
  property p_trig_bdm;
    bdm_active && !$past(reg_write) |=> !trigger;
  endproperty
  a_trig_bdm: assert property (p_trig_bdm)
    else $error("trigger while debug firmware active");
  property p_tag_bdm;
    bdm_active |=> tag_request == 3'h0;
  endproperty
  a_tag_bdm: assert property (p_tag_bdm)
    else $error("tag request while debug firmware active");
  property p_tag_cause;
    tag_request != 3'h0 |-> $past(cpu_bus.valid);
  endproperty
  a_tag_cause: assert property (p_tag_cause)
    else $error("tag request without a bus access");
  property p_bkpt_hold;
    bkpt_request && !bkpt_ack && !$past(reg_write) |=> bkpt_request;
  endproperty
  a_bkpt_hold: assert property (p_bkpt_hold)
    else $error("breakpoint request dropped before ack");
  property p_bkpt_release;
    bkpt_request && bkpt_ack |=> !bkpt_request [*2];
  endproperty
  a_bkpt_release: assert property (p_bkpt_release)
    else $error("breakpoint request kept after ack");
  property p_bkpt_cause;
    $rose(bkpt_request) |-> $past(cpu_bus.valid || tag_hit != 3'h0 || trace_full)
      || $past(reg_write, 2);
  endproperty
  a_bkpt_cause: assert property (p_bkpt_cause)
    else $error("breakpoint request without a cause");

  c_trigger: cover property (trigger);
  c_tag: cover property (tag_request != 3'h0);
  c_ack: cover property (bkpt_request && bkpt_ack);
  c_irq: cover property (irq);
endmodule
`default_nettype wire

// ===== dss_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// CPU side: bus samples, queue-head tag hits and breakpoint acceptance.
module dss_cpu_model (
  input wire logic clock,
  input wire logic reset,
  input wire logic access_valid,
  input wire logic [15:0] access_addr,
  input wire logic [15:0] noise,
  input wire logic [3:0] tag_delay,
  input wire logic [3:0] ack_delay,
  input wire logic [2:0] tag_request,
  input wire logic bkpt_request,
  output var dss_pkg::dss_bus_type cpu_bus,
  output logic [2:0] tag_hit,
  output logic bkpt_ack
);
  logic [3:0] cnt [3];
  logic [2:0] pend;
  logic [3:0] acnt;
  // Idle bus cycles carry noise so a stale address can never pass for a match.
  // A valid access carries its own address as data, so data compares are testable.
  assign cpu_bus = {access_valid, access_valid ? access_addr : noise, access_valid,
                    access_valid ? access_addr : noise};
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      pend <= 3'h0;
      tag_hit <= 3'h0;
      acnt <= 4'h0;
      bkpt_ack <= 1'b0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        tag_hit[i] <= 1'b0;
        if (tag_request[i]) begin
          pend[i] <= 1'b1;
          cnt[i] <= tag_delay;
        end else if (pend[i] && cnt[i] == 4'h0) begin
          tag_hit[i] <= 1'b1;
          pend[i] <= 1'b0;
        end else if (pend[i]) begin
          cnt[i] <= cnt[i] - 4'h1;
        end
      end
      if (bkpt_request && !bkpt_ack && acnt == ack_delay) begin
        bkpt_ack <= 1'b1;
        acnt <= 4'h0;
      end else begin
        bkpt_ack <= 1'b0;
        if (bkpt_request && !bkpt_ack) acnt <= acnt + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata;
  dss_pkg::dss_bus_type cpu_bus;
  logic [2:0] tag_hit, tag_request;
  logic bdm_active = 1'b0;
  logic trace_full = 1'b0;
  logic bkpt_ack, trigger, bkpt_request, irq;
  logic acc_valid = 1'b0;
  logic [15:0] acc_addr = 16'h0;
  logic [15:0] noise = 16'h0;
  int seed = 79;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  int n_trig = 0;
  // Targets per code as nibbles ch2,ch1,ch0: 0 none, 1..3 state, 4 final, 5 next.
  int tbl [16] = '{12'h005, 12'h050, 12'h500, 12'h004, 12'h040, 12'h400, 12'h045, 12'h444,
    12'h453, 12'h402, 12'h204, 12'h514, 12'h431, 12'h321, 12'h454, 12'h000};

  initial forever #5 clock = ~clock;

  dss_sequencer i_dut (.clock(clock), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .cpu_bus(cpu_bus), .tag_hit(tag_hit), .bdm_active(bdm_active), .trace_full(trace_full),
    .bkpt_ack(bkpt_ack), .tag_request(tag_request), .trigger(trigger),
    .bkpt_request(bkpt_request), .irq(irq));
  dss_cpu_model i_cpu (.clock(clock), .reset(reset), .access_valid(acc_valid),
    .access_addr(acc_addr), .noise(noise), .tag_delay(4'h8), .ack_delay(4'hf),
    .tag_request(tag_request), .bkpt_request(bkpt_request), .cpu_bus(cpu_bus),
    .tag_hit(tag_hit), .bkpt_ack(bkpt_ack));

  always @(posedge clock) begin
    noise <= 16'($random(seed));
    cycles++;
    if (trigger === 1'b1) n_trig++;
    if (cycles == 20000) begin
      n_errors++;
      test_done();
    end
  end

  task automatic test_done();
    $display("errors %0d of %0d checks", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic ev(input logic [15:0] a, input logic b);
    @(posedge clock);
    acc_valid <= 1'b1;
    acc_addr <= a;
    bdm_active <= b;
    @(posedge clock);
    acc_valid <= 1'b0;
    bdm_active <= 1'b0;
  endtask
  function automatic int nxt(int s, int code, logic [2:0] m);
    int t;
    int r;
    r = s;
    for (int i = 2; i >= 0; i--) begin
      t = (tbl[code] >> (4 * i)) & 15;
      if (m[i] && t == 5) r = s + 1;
      else if (m[i] && t != 0 && t != 4) r = t - 1;
    end
    // From state three a next target is the final state and so takes precedence.
    for (int i = 0; i < 3; i++) begin
      t = (tbl[code] >> (4 * i)) & 15;
      if (m[i] && (t == 4 || (t == 5 && s == 2))) r = 3;
    end
    return r;
  endfunction

  initial begin : main
    logic [31:0] d;
    logic [15:0] ca [3];
    logic [15:0] a;
    logic [2:0] m;
    logic rng, b;
    int s, et, r;
    int c [3];
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    for (int k = 1; k < 4; k++) begin
      rd(8'(4 * k), d);
      check(d, 32'hf);
    end
    rd(dss_pkg::OFS_CONTROL, d);
    check(d, 32'h0);
    rd(8'h3c, d);
    check(d, 32'h0);
    // Each trial steps the state one code through its sixteen values and randomises the other two codes and the comparators; the close address
    // spacing makes coincident matches on several channels likely.
    for (int t = 0; t < 48; t++) begin
      c[0] = t % 16;
      c[1] = $random(seed) & 15;
      c[2] = $random(seed) & 15;
      for (int k = 0; k < 3; k++) ca[k] = 16'h1000 + 16'(2 * ($random(seed) & 3));
      rng = 1'($random(seed));
      for (int k = 0; k < 3; k++) wr(8'(4 * k + 4), 32'(c[k]));
      for (int k = 0; k < 3; k++) wr(8'(4 * k + 16), 32'(ca[k]));
      wr(dss_pkg::OFS_COMP_CTRL, 32'h7);
      wr(dss_pkg::OFS_CONTROL, 32'h31 | (32'(rng) << 2));
      s = 0;
      et = n_trig;
      for (int e = 0; e < 8; e++) begin
        r = $random(seed);
        a = 16'h0ffe + 16'(2 * (r & 3));
        b = (r[7:4] == 4'h0);
        m[0] = rng ? (a >= ca[0] && a <= ca[1]) : (a == ca[0]);
        m[1] = !rng && a == ca[1];
        m[2] = a == ca[2];
        ev(a, b);
        if (!b && s != 3) begin
          r = nxt(s, c[s], m);
          if (r == 3) et++;
          s = r;
        end
        rd(dss_pkg::OFS_STATUS, d);
        check(d & 32'h3, 32'(s));
      end
      check(32'(n_trig), 32'(et));
      if (s == 3) begin
        @(posedge clock);
        trace_full <= 1'b1;
        @(posedge clock);
        trace_full <= 1'b0;
      end else begin
        wr(dss_pkg::OFS_CONTROL, 32'h0);
      end
      rd(dss_pkg::OFS_STATUS, d);
      check(d & 32'h3, 32'h0);
    end
    wr(dss_pkg::OFS_COMP_A, 32'h2000);
    wr(dss_pkg::OFS_STATE_ONE, 32'h3);
    wr(dss_pkg::OFS_COMP_CTRL, 32'h9);
    wr(dss_pkg::OFS_CONTROL, 32'h49);
    et = n_trig;
    ev(16'h2000, 1'b0);
    rd(dss_pkg::OFS_STATUS, d);
    check(d & 32'h7f, 32'h10);
    for (int i = 0; i < 40 && bkpt_request !== 1'b1; i++) @(posedge clock);
    #1 check(bkpt_request, 1'b1);
    check(32'(n_trig), 32'(et + 1));
    check(irq, 1'b0);
    wr(dss_pkg::OFS_IRQ_MASK, 32'h3);
    @(posedge clock);
    #1 check(irq, 1'b1);
    for (int i = 0; i < 40 && bkpt_request !== 1'b0; i++) @(posedge clock);
    rd(dss_pkg::OFS_CONTROL, d);
    check(d, 32'h48);
    rd(dss_pkg::OFS_STATUS, d);
    check(d & 32'h7, 32'h0);
    wr(dss_pkg::OFS_IRQ_STATUS, 32'h7);
    @(posedge clock);
    #1 check(irq, 1'b0);
    et = n_trig;
    wr(dss_pkg::OFS_CONTROL, 32'h3);
    repeat (3) @(posedge clock);
    check(32'(n_trig), 32'(et + 1));
    // Data compare on channel zero, then a breakpoint held back until tracing completes.
    wr(dss_pkg::OFS_COMP_CTRL, 32'h41);
    wr(dss_pkg::OFS_COMP_DATA, 32'h2001);
    wr(dss_pkg::OFS_CONTROL, 32'h71);
    ev(16'h2000, 1'b0);
    rd(dss_pkg::OFS_STATUS, d);
    check(d & 32'hf, 32'h0);
    wr(dss_pkg::OFS_COMP_DATA, 32'h2000);
    ev(16'h2000, 1'b0);
    rd(dss_pkg::OFS_STATUS, d);
    check(d & 32'hf, 32'hb);
    @(posedge clock);
    trace_full <= 1'b1;
    @(posedge clock);
    trace_full <= 1'b0;
    #1 check(bkpt_request, 1'b1);
    for (int i = 0; i < 40 && bkpt_request !== 1'b0; i++) @(posedge clock);
    rd(dss_pkg::OFS_STATUS, d);
    check(d & 32'hf, 32'h0);
    test_done();
  end
endmodule

bind dss_sequencer dss_seq_asserts i_asserts (.clock(clock), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .cpu_bus(cpu_bus), .tag_hit(tag_hit), .bdm_active(bdm_active),
  .trace_full(trace_full), .bkpt_ack(bkpt_ack), .tag_request(tag_request),
  .trigger(trigger), .bkpt_request(bkpt_request), .irq(irq));
`default_nettype wire
